// ---- verilog/wcu_word_compare.v ----
// wcu_word_compare: comparison datapath for rung evaluation
// assumes operands already fetched from the data table (direct or indexed,
// constant or address resolved upstream) and steady while operand_valid is high
`timescale 1ns/1ns
`include "wcu_map.vh"

module wcu_word_compare (
    input wire sys_clk,
    input wire reset,
    input wire operand_valid,
    input wire [`WCU_OP_W-1:0] opcode,
    input wire [`WCU_WORD_W-1:0] operand_a,
    input wire [`WCU_WORD_W-1:0] operand_b,
    input wire [`WCU_WORD_W-1:0] mask_word,
    input wire [`WCU_WORD_W-1:0] low_bound,
    input wire [`WCU_WORD_W-1:0] high_bound,
    output reg result,
    output reg result_valid
);
    // operand sourcing (address kind, constant placement) is resolved by the
    // fetch stage; this datapath sees plain words only

    // a against b
    wire a_eq_b;
    wire a_lt_b;

    // bounds against the test value, and the bounds against each other
    wire lo_eq_t;
    wire lo_lt_t;
    wire t_eq_hi;
    wire t_lt_hi;
    wire hi_lt_lo;
    wire hi_eq_lo;

    // one outcome per relational opcode
    wire rel_same;
    wire rel_differ;
    wire rel_below;
    wire rel_at_most;
    wire rel_above;
    wire rel_at_least;

    // masked match, one flag per word position
    wire [`WCU_WORD_W-1:0] bit_match;
    wire masked_equal;

    // range window
    wire low_le_test;
    wire test_le_high;
    wire inside_window;
    wire outside_window;
    reg window_result;

    // staged result
    reg next_result;

    genvar bit_idx;

    wcu_signed_order u_ab (
        .left_word(operand_a),
        .right_word(operand_b),
        .is_equal(a_eq_b),
        .is_below(a_lt_b)
    );

    // range test value rides on operand_a
    wcu_signed_order u_lo_t (
        .left_word(low_bound),
        .right_word(operand_a),
        .is_equal(lo_eq_t),
        .is_below(lo_lt_t)
    );

    wcu_signed_order u_t_hi (
        .left_word(operand_a),
        .right_word(high_bound),
        .is_equal(t_eq_hi),
        .is_below(t_lt_hi)
    );

    // order of the bounds picks the window kind
    wcu_signed_order u_hi_lo (
        .left_word(high_bound),
        .right_word(low_bound),
        .is_equal(hi_eq_lo),
        .is_below(hi_lt_lo)
    );

    // all six relational tests share the one a/b comparator
    assign rel_same = a_eq_b;
    assign rel_differ = ~a_eq_b;
    assign rel_below = a_lt_b;
    assign rel_at_most = a_lt_b | a_eq_b;
    assign rel_above = ~(a_lt_b | a_eq_b);
    assign rel_at_least = ~a_lt_b;

    generate
        for (bit_idx = 0; bit_idx < `WCU_WORD_W; bit_idx = bit_idx + 1) begin : g_mask_bit
            wire bit_same;
            assign bit_same = ~(operand_a[bit_idx] ^ operand_b[bit_idx]);
            // mask one keeps the position, zero drops it
            assign bit_match[bit_idx] = bit_same | ~mask_word[bit_idx];
        end
    endgenerate

    // a single kept mismatch makes the whole test false
    assign masked_equal = &bit_match;

    assign low_le_test = lo_lt_t | lo_eq_t;
    assign test_le_high = t_lt_hi | t_eq_hi;
    assign inside_window = low_le_test & test_le_high;
    assign outside_window = test_le_high | low_le_test;

    always @* begin
        window_result = 1'h0;
        if (hi_lt_lo) begin
            // inverted window: true at either bound and beyond them
            window_result = outside_window;
        end else if (hi_eq_lo) begin
            // equal bounds: a plain window one value wide
            window_result = lo_eq_t;
        end else begin
            window_result = inside_window;
        end
    end

    always @* begin
        next_result = 1'h0;
        case (opcode)
            `WCU_OP_SAME_VALUE: begin
                next_result = rel_same;
            end
            `WCU_OP_DIFFER: begin
                next_result = rel_differ;
            end
            `WCU_OP_BELOW: begin
                next_result = rel_below;
            end
            `WCU_OP_AT_MOST: begin
                next_result = rel_at_most;
            end
            `WCU_OP_ABOVE: begin
                next_result = rel_above;
            end
            `WCU_OP_AT_LEAST: begin
                next_result = rel_at_least;
            end
            `WCU_OP_MASKED_MATCH: begin
                next_result = masked_equal;
            end
            `WCU_OP_RANGE_WINDOW: begin
                next_result = window_result;
            end
            default: begin
                next_result = 1'h0;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            result_valid <= `WCU_VALID_RST;
        end else begin
            result_valid <= operand_valid;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            result <= `WCU_RESULT_RST;
        end else begin
            // held low between evaluations so a stale true never continues a rung
            result <= operand_valid & next_result;
        end
    end
endmodule // wcu_word_compare

// ---- shared/wcu_map.vh ----
// word compare unit: opcode encodings, widths and reset values
// assumes the includer works on 16-bit two's-complement words
//
// Function
// - result is high only when the selected comparison succeeds; it gates rung continuity
// - same_value_test: true when A equals B, else false
// - differ_test: true when A differs from B, false when identical
// - below_test: true when A strictly below B, else false
// - at_most_test: true when A not above B, else false
// - above_test: true when A strictly above B, else false
// - at_least_test: true when A not below B, else false
// - relational tests treat operands as signed two's-complement values
// - word-address operands may be direct or indexed
// - masked_match_test: true when all unmasked 16 bits match the reference
// - mask bit one includes the position, zero excludes it
// - range_window_test, low not above high: true inclusively between bounds
// - range_window_test, low above high: false strictly between, true at bounds or outside
`ifndef WCU_MAP_VH
`define WCU_MAP_VH

`define WCU_WORD_W 16
`define WCU_OP_W 3

`define WCU_OP_SAME_VALUE 3'h0
`define WCU_OP_DIFFER 3'h1
`define WCU_OP_BELOW 3'h2
`define WCU_OP_AT_MOST 3'h3
`define WCU_OP_ABOVE 3'h4
`define WCU_OP_AT_LEAST 3'h5
`define WCU_OP_MASKED_MATCH 3'h6
`define WCU_OP_RANGE_WINDOW 3'h7

`define WCU_RESULT_RST 1'h0
`define WCU_VALID_RST 1'h0

`endif

// ---- verilog/wcu_signed_order.v ----
// wcu_signed_order: signed ordering of two 16-bit words
// purely combinational; caller registers the outputs
`timescale 1ns/1ns
`include "wcu_map.vh"

module wcu_signed_order (
    input wire [`WCU_WORD_W-1:0] left_word,
    input wire [`WCU_WORD_W-1:0] right_word,
    output wire is_equal,
    output wire is_below
);
    // signed view so negative words order below zero
    assign is_equal = (left_word == right_word);
    assign is_below = ($signed(left_word) < $signed(right_word));
endmodule // wcu_signed_order

// ---- tb/wcu_word_compare_monitor.sv ----
// port assertions for wcu_word_compare
// bound to every instance of it
`timescale 1ns/1ns
module wcu_word_compare_monitor (
    input wire sys_clk,
    input wire reset,
    input wire operand_valid,
    input wire [2:0] opcode,
    input wire [15:0] operand_a,
    input wire [15:0] operand_b,
    input wire [15:0] mask_word,
    input wire [15:0] low_bound,
    input wire [15:0] high_bound,
    input wire result,
    input wire result_valid
);
    logic v;
    logic [2:0] o;
    logic signed [15:0] a, b, m, l, h;
    always @(posedge sys_clk) begin
        v <= operand_valid && !reset;
        {o, a, b, m, l, h} <= {opcode, operand_a, operand_b, mask_word, low_bound, high_bound};
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_valid_lag: assert property (result_valid == v) else $error("lag");
    a_idle_low: assert property (!v |-> !result) else $error("idle");
    a_equal_ops: assert property (v && o < 3'h2 |-> result == ((a == b) ^ o[0])) else $error("eq");
    a_below_ops: assert property (v && (o == 3'h2 || o == 3'h5) |-> result == ((a < b) ^ o[0]))
        else $error("lt");
    a_above_ops: assert property (v && (o == 3'h4 || o == 3'h3) |-> result == ((a > b) ^ o[0]))
        else $error("gt");
    a_mask_match: assert property (v && o == 3'h6 |-> result == !((a ^ b) & m)) else $error("mask");
    a_window_in: assert property (v && o == 3'h7 && l <= h |-> result == (a >= l && a <= h))
        else $error("in");
    a_window_out: assert property (v && o == 3'h7 && l > h |-> result == (a <= h || a >= l))
        else $error("out");
endmodule // wcu_word_compare_monitor
bind wcu_word_compare wcu_word_compare_monitor wcu_word_compare_monitor_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .operand_valid(operand_valid),
    .opcode(opcode),
    .operand_a(operand_a),
    .operand_b(operand_b),
    .mask_word(mask_word),
    .low_bound(low_bound),
    .high_bound(high_bound),
    .result(result),
    .result_valid(result_valid)
);

// ---- tb/wcu_word_compare_tb_top.sv ----
// self-checking bench for wcu_word_compare
// bench drives every port itself
`timescale 1ns/1ns
module wcu_word_compare_tb_top;
    logic sys_clk = 0, reset = 1, operand_valid = 0, result, result_valid;
    logic [2:0] opcode = 3'h0;
    logic [15:0] operand_a = 16'h0, operand_b = 16'h0, mask_word = 16'h0, low_bound = 16'h0, high_bound = 16'h0;
    integer err_count = 0, n_tests = 0, seed = 84417, i;
    wcu_word_compare wcu_word_compare_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .operand_valid(operand_valid),
        .opcode(opcode),
        .operand_a(operand_a),
        .operand_b(operand_b),
        .mask_word(mask_word),
        .low_bound(low_bound),
        .high_bound(high_bound),
        .result(result),
        .result_valid(result_valid)
    );
    initial forever #50 sys_clk = ~sys_clk;
    task check(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t got %b", $time, seen);
        end
    endtask
    task end_sim;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function logic f(input [2:0] p, input signed [15:0] a, b, m, l, h);
        f = p == 3'h0 ? a == b : p == 3'h1 ? a != b : p == 3'h2 ? a < b : p == 3'h3 ? a <= b : p == 3'h4 ? a > b
            : p == 3'h5 ? a >= b : p == 3'h6 ? !((a ^ b) & m) : l <= h ? a >= l && a <= h : a <= h || a >= l;
    endfunction
    task run(input [2:0] p, input [15:0] a, b, m, l, h);
        @(posedge sys_clk);
        {operand_valid, opcode, operand_a, operand_b, mask_word, low_bound, high_bound} <= {1'h1, p, a, b, m, l, h};
        @(posedge sys_clk);
        #1 check(result, f(p, a, b, m, l, h));
        check(result_valid, 1'h1);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 0;
        // most negative against most positive exposes unsigned ordering
        for (i = 0; i < 8; i++) run(i, 16'h8000, 16'h7FFF, 16'h00F0, 16'h0005, 16'h0008);
        for (i = 4; i < 10; i++) begin
            run(3'h7, i, 16'h0, 16'h0, 16'h0005, 16'h0008);
            run(3'h7, i, 16'h0, 16'h0, 16'h0008, 16'h0005);
        end
        // small operands so equality and bound hits are frequent; any word may stand for a constant or address
        for (i = 0; i < 300; i++) run($random(seed), $random(seed) % 4, $random(seed) % 4,
            $random(seed), $random(seed) % 8, $random(seed) % 8);
        @(posedge sys_clk) reset <= 1;
        @(posedge sys_clk) reset <= 0;
        #1 check(result_valid, 1'h0);
        check(result, 1'h0);
        @(posedge sys_clk) operand_valid <= 0;
        #1 check(result_valid, 1'h1);
        check(result, f(opcode, operand_a, operand_b, mask_word, low_bound, high_bound));
        @(posedge sys_clk) #1 check(result, 1'h0);
        check(result_valid, 1'h0);
        end_sim;
    end
    initial begin
        #200000;
        err_count++;
        end_sim;
    end
endmodule // wcu_word_compare_tb_top
